// ==== src/port_e_pin_pkg.sv ====
// constants, register layout and types for the port e / port j pin function block
// Function
// - port e line 3 is general I/O, resets as input with pull-up.
// - line 3 acts as low-byte strobe only once strobe enable is set.
// - wide and emulation narrow modes with tagging: strobe pin doubles as tag input.
// - tagging on: low tag pin at bus clock fall tags fetched low byte.
// - line 2 resets input with pull-up, drives read/write only once enabled.
// - line 1 always readable input and maskable interrupt request pin.
// - reset sets maskable block flag; pin interrupts blocked until software clears it.
// - maskable pin triggers on falling edge or low level per edge select.
// - after reset maskable pin is enabled and level sensitive.
// - clearing request pin enable disables maskable pin requests.
// - lines 1 and 0 pull-ups on at reset, off when pull-up enable cleared.
// - line 0 readable non-maskable request; reset sets guard flag blocking it.
// - non-maskable pin is level sensitive, suits wired-or sharing.
// - expanded modes: port j line 2 latched into rom enable at reset release.
// - stick host enabled: port j line 2 becomes its serial clock.
// - port j line 2 is high-impedance input without pull at reset.
package port_e_pin_pkg;

  // ******************************************
  // register offsets
  // ******************************************
  localparam logic [3:0] OFF_PORT_E_ASSIGN = 4'h0;
  localparam logic [3:0] OFF_REQUEST_CTRL  = 4'h1;
  localparam logic [3:0] OFF_PULLUP_CTRL   = 4'h2;
  localparam logic [3:0] OFF_COND_CODE     = 4'h3;
  localparam logic [3:0] OFF_PORT_E_DATA   = 4'h4;
  localparam logic [3:0] OFF_PORT_E_DIR    = 4'h5;
  localparam logic [3:0] OFF_SYS_CFG       = 4'h6;
  localparam logic [3:0] OFF_PORT_J        = 4'h7;
  localparam logic [3:0] OFF_IRQ_STATUS    = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK      = 4'h9;

  // ******************************************
  // field positions
  // ******************************************
  localparam int STAT_MASKABLE    = 0;
  localparam int STAT_NONMASKABLE = 1;
  localparam int STAT_TAG         = 2;
  localparam int PJ_OUT           = 0;
  localparam int PJ_DIR           = 1;
  localparam int PJ_PIN           = 2;

  // ******************************************
  // reset values
  // ******************************************
  localparam logic [7:0] RST_PORT_E_ASSIGN = 8'h00;
  localparam logic [7:0] RST_REQUEST_CTRL  = 8'h02;
  localparam logic [7:0] RST_PULLUP_CTRL   = 8'h01;
  localparam logic [7:0] RST_COND_CODE     = 8'h03;
  localparam logic [7:0] RST_IRQ_MASK      = 8'h00;
  localparam logic [1:0] STRAP_WAIT        = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXP_NARROW,
    MODE_EXP_WIDE,
    MODE_EMUL_NARROW
  } bus_mode_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       tag_enable;
    logic       rw_pin_enable;
    logic       strobe_pin_enable;
  } port_e_assign_t;

  typedef struct packed {
    logic [5:0] unused;
    logic       request_pin_enable;
    logic       edge_select_bit;
  } request_ctrl_t;

  typedef struct packed {
    logic [5:0] unused;
    logic       x_guard;
    logic       i_block;
  } cond_code_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : port_e_pin_pkg

// ==== src/port_e_pin_function_logic.sv ====
// pin function, interrupt conditioning and strap capture for port e and port j line 2
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_function_logic
  import port_e_pin_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire reg_req_t   reg_req_i,
  output var  logic [7:0] reg_rdata_o,
  input  wire bus_mode_t  bus_mode_i,
  input  wire logic       external_bus_clock_i,
  input  wire logic       bus_low_byte_strobe_n_i,
  input  wire logic       bus_read_write_i,
  input  wire logic       stick_serial_clock_i,
  input  wire logic       port_e_line_3_i,
  output var  logic       port_e_line_3_o,
  output var  logic       port_e_line_3_oe_o,
  output var  logic       port_e_line_3_pullup_o,
  input  wire logic       port_e_line_2_i,
  output var  logic       port_e_line_2_o,
  output var  logic       port_e_line_2_oe_o,
  output var  logic       port_e_line_2_pullup_o,
  input  wire logic       port_e_line_1_i,
  input  wire logic       port_e_line_0_i,
  output var  logic       port_e_line_1_0_pullup_o,
  input  wire logic       port_j_line_2_i,
  output var  logic       port_j_line_2_o,
  output var  logic       port_j_line_2_oe_o,
  output var  logic       port_j_line_2_pullup_o,
  output var  logic       maskable_req_o,
  output var  logic       nonmaskable_req_o,
  output var  logic       low_byte_tag_o,
  output var  logic       irq_o
);

  // ******************************************
  // registers
  // ******************************************
  port_e_assign_t assign_q;
  request_ctrl_t  req_ctrl_q;
  logic           pullup_en_q;
  cond_code_t     ccr_q;
  logic [3:2]     pe_out_q;
  logic [3:2]     pe_dir_q;
  logic           stick_host_en_q;
  logic           rom_enable_q;
  logic [1:0]     pj_ctrl_q;
  logic [2:0]     irq_status_q;
  logic [2:0]     irq_mask_q;
  logic [7:0]     rdata_q;

  logic [4:0]     sync1_q;
  logic [4:0]     sync2_q;
  logic           irq_pin_d1_q;
  logic           ebc_d1_q;
  logic           edge_pend_q;
  logic [1:0]     strap_cnt_q;
  logic           strap_done_q;

  logic           wr_hit;
  logic           rd_status;
  logic           tag_mode;
  logic           irq_fall;
  logic           ebc_fall;
  logic           mask_req;
  logic           nmask_req;
  logic           tag_hit;
  logic [2:0]     events;

  // synced pin order: 0 line0, 1 line1, 2 line2, 3 line3, 4 port j line 2
  assign wr_hit    = reg_req_i.wr;
  assign rd_status = reg_req_i.rd && (reg_req_i.addr == OFF_IRQ_STATUS);
  assign tag_mode  = assign_q.tag_enable &&
                     ((bus_mode_i == MODE_EXP_WIDE) || (bus_mode_i == MODE_EMUL_NARROW));
  assign irq_fall  = irq_pin_d1_q && !sync2_q[1];
  assign ebc_fall  = ebc_d1_q && !external_bus_clock_i;
  assign mask_req  = req_ctrl_q.request_pin_enable &&
                     (req_ctrl_q.edge_select_bit ? edge_pend_q : !sync2_q[1]);
  assign nmask_req = !sync2_q[0];
  assign tag_hit   = tag_mode && ebc_fall && !sync2_q[3];
  assign events    = {tag_hit, nmask_req && !ccr_q.x_guard, mask_req && !ccr_q.i_block};
  assign reg_rdata_o = rdata_q;

  // ******************************************
  // pin synchroniser
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {port_j_line_2_i, port_e_line_3_i, port_e_line_2_i,
                  port_e_line_1_i, port_e_line_0_i};
      sync2_q <= sync1_q;
    end
  end

  // ******************************************
  // edge detection
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_pin_d1_q <= 1'b1;
      ebc_d1_q     <= 1'b0;
      edge_pend_q  <= 1'b0;
    end else begin
      irq_pin_d1_q <= sync2_q[1];
      ebc_d1_q     <= external_bus_clock_i;
      if (irq_fall && req_ctrl_q.request_pin_enable) begin
        edge_pend_q <= 1'b1;
      end else if (rd_status || !req_ctrl_q.edge_select_bit) begin
        edge_pend_q <= 1'b0;
      end
    end
  end

  // ******************************************
  // control registers
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      assign_q        <= port_e_assign_t'(RST_PORT_E_ASSIGN);
      req_ctrl_q      <= request_ctrl_t'(RST_REQUEST_CTRL);
      pullup_en_q     <= RST_PULLUP_CTRL[0];
      ccr_q           <= cond_code_t'(RST_COND_CODE);
      pe_out_q        <= 2'h0;
      pe_dir_q        <= 2'h0;
      stick_host_en_q <= 1'b0;
      pj_ctrl_q       <= 2'h0;
      irq_mask_q      <= RST_IRQ_MASK[2:0];
    end else if (wr_hit) begin
      case (reg_req_i.addr)
        OFF_PORT_E_ASSIGN: assign_q <= port_e_assign_t'({5'h00, reg_req_i.wdata[2:0]});
        OFF_REQUEST_CTRL:  req_ctrl_q <= request_ctrl_t'({6'h00, reg_req_i.wdata[1:0]});
        OFF_PULLUP_CTRL:   pullup_en_q <= reg_req_i.wdata[0];
        OFF_COND_CODE: begin
          ccr_q.i_block <= reg_req_i.wdata[0];
          // guard only clears, as on the processor
          ccr_q.x_guard <= ccr_q.x_guard & reg_req_i.wdata[1];
        end
        OFF_PORT_E_DATA:   pe_out_q <= reg_req_i.wdata[3:2];
        OFF_PORT_E_DIR:    pe_dir_q <= reg_req_i.wdata[3:2];
        OFF_SYS_CFG:       stick_host_en_q <= reg_req_i.wdata[1];
        OFF_PORT_J:        pj_ctrl_q <= reg_req_i.wdata[1:0];
        OFF_IRQ_MASK:      irq_mask_q <= reg_req_i.wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // ******************************************
  // rom enable strap
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      rom_enable_q <= 1'b1;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        // pin level after release, once through the synchroniser
        rom_enable_q <= (bus_mode_i == MODE_SINGLE_CHIP) ? 1'b1 : sync2_q[4];
      end
    end
  end

  // ******************************************
  // interrupt status and mask
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_q <= 3'h0;
    end else begin
      // set wins over the clearing read
      irq_status_q <= (rd_status ? 3'h0 : irq_status_q) | events;
    end
  end

  // ******************************************
  // read data
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        OFF_PORT_E_ASSIGN: rdata_q <= assign_q;
        OFF_REQUEST_CTRL:  rdata_q <= req_ctrl_q;
        OFF_PULLUP_CTRL:   rdata_q <= {7'h00, pullup_en_q};
        OFF_COND_CODE:     rdata_q <= ccr_q;
        OFF_PORT_E_DATA:   rdata_q <= {4'h0, sync2_q[3:0]};
        OFF_PORT_E_DIR:    rdata_q <= {4'h0, pe_dir_q, 2'h0};
        OFF_SYS_CFG:       rdata_q <= {6'h00, stick_host_en_q, rom_enable_q};
        OFF_PORT_J:        rdata_q <= {5'h00, sync2_q[4], pj_ctrl_q};
        OFF_IRQ_STATUS:    rdata_q <= {5'h00, irq_status_q};
        OFF_IRQ_MASK:      rdata_q <= {5'h00, irq_mask_q};
        default:           rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ******************************************
  // pin drivers and request outputs
  // ******************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port_e_line_3_o          <= 1'b0;
      port_e_line_3_oe_o       <= 1'b0;
      port_e_line_3_pullup_o   <= 1'b1;
      port_e_line_2_o          <= 1'b0;
      port_e_line_2_oe_o       <= 1'b0;
      port_e_line_2_pullup_o   <= 1'b1;
      port_e_line_1_0_pullup_o <= 1'b1;
      port_j_line_2_o          <= 1'b0;
      port_j_line_2_oe_o       <= 1'b0;
      port_j_line_2_pullup_o   <= 1'b0;
      maskable_req_o           <= 1'b0;
      nonmaskable_req_o        <= 1'b0;
      low_byte_tag_o           <= 1'b0;
      irq_o                    <= 1'b0;
    end else begin
      if (tag_mode) begin
        // tag input takes the pin; strobe not driven
        port_e_line_3_o    <= 1'b0;
        port_e_line_3_oe_o <= 1'b0;
      end else if (assign_q.strobe_pin_enable) begin
        port_e_line_3_o    <= bus_low_byte_strobe_n_i;
        port_e_line_3_oe_o <= 1'b1;
      end else begin
        port_e_line_3_o    <= pe_out_q[3];
        port_e_line_3_oe_o <= pe_dir_q[3];
      end
      port_e_line_3_pullup_o <= !port_e_line_3_oe_o && !assign_q.strobe_pin_enable;
      if (assign_q.rw_pin_enable) begin
        port_e_line_2_o    <= bus_read_write_i;
        port_e_line_2_oe_o <= 1'b1;
      end else begin
        port_e_line_2_o    <= pe_out_q[2];
        port_e_line_2_oe_o <= pe_dir_q[2];
      end
      port_e_line_2_pullup_o   <= !assign_q.rw_pin_enable && !pe_dir_q[2];
      port_e_line_1_0_pullup_o <= pullup_en_q;
      if (stick_host_en_q) begin
        port_j_line_2_o    <= stick_serial_clock_i;
        port_j_line_2_oe_o <= 1'b1;
      end else begin
        port_j_line_2_o    <= pj_ctrl_q[PJ_OUT];
        port_j_line_2_oe_o <= pj_ctrl_q[PJ_DIR];
      end
      port_j_line_2_pullup_o <= 1'b0;
      // level request lines rely on the source holding low until serviced
      maskable_req_o    <= events[STAT_MASKABLE];
      nonmaskable_req_o <= events[STAT_NONMASKABLE];
      low_byte_tag_o    <= events[STAT_TAG];
      irq_o             <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule : port_e_pin_function_logic
`default_nettype wire

// ==== bench/port_e_pin_chk.sv ====
// concurrent checks on the port e / port j pin function block
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_chk
  import port_e_pin_pkg::*;
(
  input wire logic      mclk_i,
  input wire logic      rst_i,
  input wire reg_req_t  reg_req_i,
  input wire bus_mode_t bus_mode_i,
  input wire logic      bus_low_byte_strobe_n_i,
  input wire logic      port_e_line_0_i,
  input wire logic      port_e_line_3_o,
  input wire logic      port_e_line_3_oe_o,
  input wire logic      port_e_line_1_0_pullup_o,
  input wire logic      port_j_line_2_pullup_o,
  input wire logic      maskable_req_o,
  input wire logic      nonmaskable_req_o,
  input wire logic      low_byte_tag_o
);
  // ****************************
  // shadow of written control bits
  // ****************************
  logic blk_q, grd_q, en_q, sen_q, tag_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {blk_q, grd_q, en_q, sen_q, tag_q} <= 5'h1c;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == OFF_COND_CODE) begin
        blk_q <= reg_req_i.wdata[0];
        grd_q <= grd_q & reg_req_i.wdata[1];
      end
      if (reg_req_i.addr == OFF_REQUEST_CTRL) en_q <= reg_req_i.wdata[1];
      if (reg_req_i.addr == OFF_PORT_E_ASSIGN) begin
        sen_q <= reg_req_i.wdata[0];
        tag_q <= reg_req_i.wdata[2];
      end
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ****************************
  // assertions
  // ****************************
  a_pull_release:
    assert property (reg_req_i.wr && reg_req_i.addr == OFF_PULLUP_CTRL && !reg_req_i.wdata[0]
      |-> ##[1:2] !port_e_line_1_0_pullup_o) else $error("pull-up stayed on");
  a_portj_nopull:
    assert property (!port_j_line_2_pullup_o) else $error("port j pull device on");
  a_nmi_level:
    assert property (nonmaskable_req_o |-> !$past(port_e_line_0_i, 3)
      || !$past(port_e_line_0_i, 4)) else $error("nonmaskable request without low pin");
  a_nmi_guard:
    assert property (nonmaskable_req_o |-> !$past(grd_q)) else $error("guard flag ignored");
  a_irq_block:
    assert property (maskable_req_o |-> !$past(blk_q)) else $error("block flag ignored");
  a_irq_disable:
    assert property (maskable_req_o |-> $past(en_q)) else $error("disabled pin requested");
  a_strobe_follow:
    assert property ($past(sen_q) && !$past(tag_q) |-> port_e_line_3_oe_o
      && port_e_line_3_o == $past(bus_low_byte_strobe_n_i)) else $error("strobe not driven");
  a_tag_mode:
    assert property (low_byte_tag_o |-> $past(tag_q) && $past(bus_mode_i[1]))
      else $error("tag outside tag mode");
endmodule : port_e_pin_chk

bind port_e_pin_function_logic port_e_pin_chk u_chk (
  .mclk_i, .rst_i, .reg_req_i, .bus_mode_i, .bus_low_byte_strobe_n_i, .port_e_line_0_i,
  .port_e_line_3_o, .port_e_line_3_oe_o, .port_e_line_1_0_pullup_o, .port_j_line_2_pullup_o,
  .maskable_req_o, .nonmaskable_req_o, .low_byte_tag_o
);
`default_nettype wire

// ==== bench/request_source_model.sv ====
// open-drain request sources and port j strap device
`timescale 1ns/1ps
`default_nettype none
module request_source_model (
  input  wire logic       mclk_i,
  input  wire logic       pullup_i,
  input  wire logic       hold_mask_i,
  input  wire logic [1:0] hold_nmi_i,
  input  wire logic       strap_i,
  input  wire logic       pj_oe_i,
  input  wire logic       pj_o_i,
  output var  logic       line_1_o,
  output var  logic       line_0_o,
  output var  logic       pj_pin_o
);
  logic float_q = 1'b0;
  // an unpulled, undriven line wanders
  always @(posedge mclk_i) float_q <= ~float_q;
  // source holds low until released
  assign line_1_o = hold_mask_i ? 1'b0 : (pullup_i ? 1'b1 : float_q);
  // two sources wired-or on the level line
  assign line_0_o = (|hold_nmi_i) ? 1'b0 : (pullup_i ? 1'b1 : float_q);
  // strap device unless the pin itself drives
  assign pj_pin_o = pj_oe_i ? pj_o_i : strap_i;
endmodule : request_source_model
`default_nettype wire

// ==== bench/test_port_e_pin_function_logic.sv ====
// self-checking bench for the port e / port j pin function block
`timescale 1ns/1ps
`default_nettype none
module test_port_e_pin_function_logic
  import port_e_pin_pkg::*;
;
  logic       mclk_i = 0, rst_i = 1, ebc = 0, strb_n = 1, rw = 1, stick = 0;
  logic       l3 = 1, l2 = 1, hold_m = 0, strap = 0;
  logic [1:0] hold_n = 0;
  reg_req_t   req = '0;
  bus_mode_t  mode = MODE_EXP_WIDE;
  logic [7:0] rdata;
  logic       l3_o, l3_oe, l3_pu, l2_o, l2_oe, l2_pu, l1_pin, l0_pin, pu10;
  logic       pj_pin, pj_o, pj_oe, pj_pu, mreq, nreq, tag, irq;
  int         mismatches = 0, checked = 0, cyc = 0, ntag = 0;

  always #25 mclk_i = ~mclk_i;

  port_e_pin_function_logic u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .bus_mode_i(mode), .external_bus_clock_i(ebc), .bus_low_byte_strobe_n_i(strb_n),
    .bus_read_write_i(rw), .stick_serial_clock_i(stick),
    .port_e_line_3_i(l3_oe ? l3_o : l3), .port_e_line_3_o(l3_o),
    .port_e_line_3_oe_o(l3_oe), .port_e_line_3_pullup_o(l3_pu),
    .port_e_line_2_i(l2_oe ? l2_o : l2), .port_e_line_2_o(l2_o),
    .port_e_line_2_oe_o(l2_oe), .port_e_line_2_pullup_o(l2_pu),
    .port_e_line_1_i(l1_pin), .port_e_line_0_i(l0_pin), .port_e_line_1_0_pullup_o(pu10),
    .port_j_line_2_i(pj_pin), .port_j_line_2_o(pj_o), .port_j_line_2_oe_o(pj_oe),
    .port_j_line_2_pullup_o(pj_pu), .maskable_req_o(mreq), .nonmaskable_req_o(nreq),
    .low_byte_tag_o(tag), .irq_o(irq)
  );

  request_source_model u_src (
    .mclk_i(mclk_i), .pullup_i(pu10), .hold_mask_i(hold_m), .hold_nmi_i(hold_n),
    .strap_i(strap), .pj_oe_i(pj_oe), .pj_o_i(pj_o), .line_1_o(l1_pin),
    .line_0_o(l0_pin), .pj_pin_o(pj_pin)
  );

  // ****************************
  // access and checking tasks
  // ****************************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i) req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i) req.rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask : rd

  task automatic waitc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : waitc

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      final_report;
    end
  end

  // ****************************
  // main sequence
  // ****************************
  initial begin
    waitc(16);
    chk("pullups", {l3_pu, l2_pu, pu10}, 8'h07);
    chk("pj_state", {pj_oe, pj_pu}, 8'h00);
    @(posedge mclk_i) rst_i <= 1'b0;
    rd(OFF_PORT_E_ASSIGN, 8'h00);
    rd(OFF_REQUEST_CTRL, 8'h02);
    rd(OFF_PULLUP_CTRL, 8'h01);
    rd(OFF_COND_CODE, 8'h03);
    rd(4'hf, 8'h00);
    rd(OFF_SYS_CFG, 8'h00);
    @(posedge mclk_i) hold_m <= 1'b1;
    waitc(6);
    rd(OFF_PORT_E_DATA, 8'h0d);
    chk("mreq", mreq, 8'h00);
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_COND_CODE, 8'h02);
    waitc(6);
    chk("mreq_irq", {mreq, irq}, 8'h03);
    wr(OFF_REQUEST_CTRL, 8'h00);
    waitc(6);
    chk("mreq", mreq, 8'h00);
    @(posedge mclk_i) hold_m <= 1'b0;
    rd(OFF_IRQ_STATUS, 8'h01);
    waitc(3);
    chk("irq", irq, 8'h00);
    wr(OFF_REQUEST_CTRL, 8'h03);
    waitc(6);
    chk("mreq", mreq, 8'h00);
    @(posedge mclk_i) hold_m <= 1'b1;
    waitc(6);
    chk("mreq", mreq, 8'h01);
    @(posedge mclk_i) hold_m <= 1'b0;
    waitc(6);
    chk("mreq", mreq, 8'h01);
    rd(OFF_IRQ_STATUS, 8'h01);
    waitc(4);
    chk("mreq", mreq, 8'h00);
    @(posedge mclk_i) hold_n <= 2'b01;
    waitc(6);
    chk("nreq", nreq, 8'h00);
    wr(OFF_COND_CODE, 8'h00);
    waitc(6);
    chk("nreq", nreq, 8'h01);
    @(posedge mclk_i) hold_n <= 2'b10;
    waitc(6);
    chk("nreq", nreq, 8'h01);
    @(posedge mclk_i) hold_n <= 2'b00;
    waitc(6);
    chk("nreq", nreq, 8'h00);
    wr(OFF_COND_CODE, 8'h03);
    rd(OFF_COND_CODE, 8'h01);
    chk("line_oe", {l3_oe, l2_oe}, 8'h00);
    wr(OFF_PORT_E_ASSIGN, 8'h01);
    waitc(3);
    chk("line2_oe", l2_oe, 8'h00);
    wr(OFF_PORT_E_ASSIGN, 8'h03);
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk_i) {strb_n, rw} <= {v[0], ~v[0]};
      waitc(3);
      chk("strobe", {l3_oe, l3_o}, {7'h01, v[0]});
      chk("rw", {l2_oe, l2_o}, {7'h01, ~v[0]});
    end
    wr(OFF_PORT_E_ASSIGN, 8'h04);
    @(posedge mclk_i) l3 <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      @(posedge mclk_i) ebc <= i[1];
      #1 if (tag === 1'b1) ntag++;
    end
    chk("tag", ntag > 0, 8'h01);
    chk("line3_oe", l3_oe, 8'h00);
    wr(OFF_SYS_CFG, 8'h02);
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk_i) stick <= ~v[0];
      waitc(3);
      chk("stick", {pj_oe, pj_o}, {7'h01, ~v[0]});
    end
    rd(OFF_SYS_CFG, 8'h02);
    wr(OFF_PULLUP_CTRL, 8'h00);
    waitc(3);
    chk("pu10", pu10, 8'h00);
    // mid-run resets: single chip forces rom on, narrow expanded takes the low strap
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i) begin
        rst_i <= 1'b1;
        mode  <= (k == 0) ? MODE_SINGLE_CHIP : MODE_EXP_NARROW;
      end
      waitc(4);
      chk("rst_pins", {l3_pu, l2_pu, pu10, pj_oe, pj_pu, irq}, 8'h38);
      @(posedge mclk_i) rst_i <= 1'b0;
      waitc(2);
      chk("pullups_out", {l3_pu, l2_pu, pu10}, 8'h07);
      rd(OFF_SYS_CFG, {7'h00, ~k[0]});
    end
    // narrow expanded mode: tagging enabled but no tag function
    wr(OFF_PORT_E_ASSIGN, 8'h04);
    ntag = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i) ebc <= i[1];
      #1 if (tag === 1'b1) ntag++;
    end
    chk("tag_narrow", ntag > 0, 8'h00);
    final_report;
  end
endmodule : test_port_e_pin_function_logic
`default_nettype wire
